// ---- design/pcs_params.svh ----
// Register offsets, field positions, reset values and counts for the
// serial coding channel. Included by the channel and its bench.
`ifndef PCS_PARAMS_SVH
`define PCS_PARAMS_SVH

// APB register byte offsets
`define REG_CTRL        8'h00
`define REG_COMMA       8'h04
`define REG_SLIP        8'h08
`define REG_DUAL        8'h0C
`define REG_STATUS      8'h10
`define REG_CTC_CNT     8'h14
`define REG_SKIP        8'h18

// Control register fields
`define CTRL_RX_INV     0
`define CTRL_TX_INV     1
`define CTRL_BYPASS     2
`define CTRL_RAW10      3
`define CTRL_HALF       4
`define CTRL_ALIGN_EN   5
`define CTRL_CTC_EN     6
`define CTRL_RESET      7'h60

// Dual register fields
`define DUAL_INDEP_REQ  8
`define DUAL_GRANTED    16
`define DUAL_RESET      9'h001

// Status register fields
`define ST_ALIGNED      0
`define ST_EMPTY        1
`define ST_FULL         2
`define ST_CODE_ERR     3
`define ST_DISP_ERR     4
`define ST_OVERFLOW     5
`define ST_MIX_REFUSED  6

// Comma (plus-or-minus form matches) and clock compensation skip symbol
`define COMMA_RESET     10'h0FA
`define SKIP_RESET      9'h11C

// Aligner and compensation figures
`define LOS_ERR_LIMIT   3'h4
`define FIFO_DEPTH      32
`define CTC_HIGH_MARK   6'h18
`define CTC_LOW_MARK    6'h08

`endif

// ---- design/pcs_types_pkg.sv ----
// Types shared by the serial coding channel and its bench.
// Assumes the companion params header for figures.
package pcs_types_pkg;
	typedef enum logic {
		ALIGN_HUNT,
		ALIGN_LOCKED
	} align_state_t;

	typedef logic [9:0] code_word_t;
endpackage

// ---- design/pcs_fifo.sv ----
// Single-clock FIFO with a registered output word.
// Assumes one clock; both sides use valid/ready handshakes.
`timescale 1ns/1ps
`default_nettype none
module pcs_fifo #(
	parameter int WIDTH = 11,
	parameter int DEPTH = 32,
	parameter int AW    = $clog2(DEPTH)
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic      [AW+1:0]    level
);
	logic [WIDTH-1:0] mem [0:DEPTH-1];
	logic [AW-1:0]    wptr_reg;
	logic [AW-1:0]    rptr_reg;
	logic [AW:0]      cnt_reg;
	logic             push;
	logic             load;

	// Full counts only the array; output register is one extra slot
	assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
	assign push     = in_valid && in_ready;
	assign load     = (cnt_reg != '0) && (!out_valid || out_ready);
	assign level    = (AW+2)'(cnt_reg) + (AW+2)'(out_valid);

	// Storage array, no reset needed
	always_ff @(posedge pclk) begin
		if (push) begin
			mem[wptr_reg] <= in_data;
		end
	end

	// Pointers and occupancy
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wptr_reg <= '0;
			rptr_reg <= '0;
			cnt_reg  <= '0;
		end else begin
			if (push) begin
				wptr_reg <= wptr_reg + 1'b1;
			end
			if (load) begin
				rptr_reg <= rptr_reg + 1'b1;
			end
			cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(load);
		end
	end

	// Output register keeps read data off the array's path
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_valid <= 1'b0;
			out_data  <= '0;
		end else if (load) begin
			out_valid <= 1'b1;
			out_data  <= mem[rptr_reg];
		end else if (out_ready) begin
			out_valid <= 1'b0;
		end
	end
endmodule // pcs_fifo
`default_nettype wire

// ---- design/serial_pcs_channel.sv ----
// Coding sublayer for one serial channel, with APB configuration.
// Assumes deserializer words and fabric logic share pclk.
`timescale 1ns/1ps
`default_nettype none
`include "pcs_params.svh"
module serial_pcs_channel
	import pcs_types_pkg::*;
#(
	parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [9:0]  rx_word,
	input  wire logic        rx_word_valid,
	input  wire logic        bit_slip_req,
	output logic [19:0]      rx_user_data,
	output logic [1:0]       rx_user_k,
	output logic             rx_user_valid,
	input  wire logic        rx_user_ready,
	output logic             rx_word_strobe,
	input  wire logic [19:0] tx_user_data,
	input  wire logic [1:0]  tx_user_k,
	input  wire logic        tx_user_valid,
	output logic             tx_user_ready,
	output logic [9:0]       tx_word,
	output logic             tx_word_valid,
	input  wire logic        tx_ser_ready,
	output logic             tx_word_strobe,
	output logic             dual_shared
);
	localparam logic [5:0] SIX_TAB [0:31] = '{
		6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
		6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
		6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
		6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
	localparam logic [3:0] FOUR_TAB [0:7] = '{
		4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
	localparam int FAW = $clog2(FIFO_DEPTH);

	// Encoder: returns {running disparity after, abcdei fghj}; rd 1 = plus
	function automatic logic [10:0] enc_word(input logic [7:0] d,
			input logic k, input logic rd);
		logic [5:0] s;
		logic [3:0] f;
		logic       u6;
		logic       u4;
		logic       rd6;
		logic       k28;
		logic       a7;
		k28 = k && (d[4:0] == 5'h1C);
		s   = k28 ? 6'h0F : SIX_TAB[d[4:0]];
		u6  = ($countones(s) != 3);
		if (rd && (u6 || d[4:0] == 5'h07)) begin
			s = ~s;
		end
		rd6 = rd ^ u6;
		a7  = (d[7:5] == 3'h7) && (k ||
			(!rd6 && (d[4:0] == 5'h11 || d[4:0] == 5'h12 ||
				d[4:0] == 5'h14)) ||
			(rd6 && (d[4:0] == 5'h0B || d[4:0] == 5'h0D ||
				d[4:0] == 5'h0E)));
		f   = a7 ? 4'h7 : FOUR_TAB[d[7:5]];
		u4  = ($countones(f) != 2);
		// K28 neutral tails swap sense against the data codes
		if ((rd6 && (u4 || d[7:5] == 3'h3)) ||
				(k28 && !u4 && d[7:5] != 3'h3 && !rd6)) begin
			f = ~f;
		end
		return {rd6 ^ u4, s, f};
	endfunction

	// Legal control symbols: K28.x and K23/27/29/30.7
	function automatic logic k_legal(input logic [7:0] d);
		return (d[4:0] == 5'h1C) || (d[7:5] == 3'h7 &&
			(d[4:0] == 5'h17 || d[4:0] == 5'h1B ||
			 d[4:0] == 5'h1D || d[4:0] == 5'h1E));
	endfunction

	// Decoder by search: {code err, disp err, k, data, rd after}
	function automatic logic [11:0] dec_word(input logic [9:0] w,
			input logic rd);
		logic [11:0] res;
		logic [10:0] e0;
		logic [10:0] e1;
		logic        hit;
		res = {2'b10, 9'h000, rd};
		hit = 1'b0;
		for (int i = 0; i < 512; i++) begin
			if (!hit && (!i[8] || k_legal(i[7:0]))) begin
				e0 = enc_word(i[7:0], i[8], rd);
				e1 = enc_word(i[7:0], i[8], ~rd);
				if (e0[9:0] == w) begin
					res = {2'b00, i[8], i[7:0], e0[10]};
					hit = 1'b1;
				end else if (e1[9:0] == w) begin
					res = {2'b01, i[8], i[7:0], e1[10]};
					hit = 1'b1;
				end
			end
		end
		return res;
	endfunction

	// Registers
	logic [6:0]  ctrl_reg;
	logic [9:0]  comma_reg;
	logic [8:0]  dual_reg;
	logic [8:0]  skip_reg;
	logic [2:0]  sticky_reg;
	logic [15:0] ins_cnt_reg;
	logic [15:0] del_cnt_reg;
	logic        slip_pulse;
	logic        wr_en;
	logic        granted;
	logic        mix_refused;

	assign wr_en  = psel && penable && pwrite;
	assign pready = 1'b1;
	// Ratios other than x1, x2, x11 keep the dual as one unit
	assign granted = dual_reg[`DUAL_INDEP_REQ] &&
		(dual_reg[7:0] == 8'h01 || dual_reg[7:0] == 8'h02 ||
		 dual_reg[7:0] == 8'h0B);
	assign mix_refused = dual_reg[`DUAL_INDEP_REQ] && !granted;
	assign dual_shared = !granted;
	assign slip_pulse  = (wr_en && paddr == `REG_SLIP && pwdata[0]) ||
		bit_slip_req;

	// Run-time configuration writes, no restart needed
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg  <= `CTRL_RESET;
			comma_reg <= `COMMA_RESET;
			dual_reg  <= `DUAL_RESET;
			skip_reg  <= `SKIP_RESET;
		end else if (wr_en) begin
			case (paddr)
				`REG_CTRL:  ctrl_reg  <= pwdata[6:0];
				`REG_COMMA: comma_reg <= pwdata[9:0];
				`REG_DUAL:  dual_reg  <= pwdata[8:0];
				`REG_SKIP:  skip_reg  <= pwdata[8:0];
				default:    ;
			endcase
		end
	end

	// Receive front: polarity and boundary search
	align_state_t al_state_reg;
	logic [9:0]   prev_reg;
	logic [3:0]   off_reg;
	logic [3:0]   off_use;
	logic         comma_hit;
	logic [3:0]   comma_off;
	logic [9:0]   rx_pol;
	logic [19:0]  window;
	logic [2:0]   err_run_reg;
	logic [9:0]   al_word_reg;
	logic         al_valid_reg;
	logic         rx_rd_reg;
	logic [11:0]  dec;
	logic         bypass;

	assign bypass = ctrl_reg[`CTRL_BYPASS];
	assign rx_pol = rx_word ^ {10{ctrl_reg[`CTRL_RX_INV]}};
	assign window = {prev_reg, rx_pol};

	// Lowest offset holding the comma in either disparity
	always_comb begin
		comma_hit = 1'b0;
		comma_off = 4'h0;
		for (int o = 9; o >= 0; o--) begin
			if (window[19-o -: 10] == comma_reg ||
					window[19-o -: 10] == ~comma_reg) begin
				comma_hit = 1'b1;
				comma_off = 4'(o);
			end
		end
		if (!ctrl_reg[`CTRL_ALIGN_EN] || bypass) begin
			off_use = 4'hA; // Current word as it stands
		end else if (al_state_reg == ALIGN_HUNT && comma_hit) begin
			off_use = comma_off;
		end else begin
			off_use = off_reg;
		end
	end

	// Aligner state: hunt, lock, slip, loss after repeated code errors
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			al_state_reg <= ALIGN_HUNT;
			off_reg      <= 4'h0;
			err_run_reg  <= 3'h0;
		end else if (slip_pulse) begin
			off_reg      <= (off_reg == 4'h9) ? 4'h0 : off_reg + 4'h1;
			al_state_reg <= ALIGN_LOCKED;
			err_run_reg  <= 3'h0;
		end else if (rx_word_valid) begin
			case (al_state_reg)
				ALIGN_HUNT: begin
					if (comma_hit) begin
						al_state_reg <= ALIGN_LOCKED;
						off_reg      <= comma_off;
						err_run_reg  <= 3'h0;
					end
				end
				// Words may come every cycle: count runs here too
				ALIGN_LOCKED: begin
					if (err_run_reg >= `LOS_ERR_LIMIT) begin
						al_state_reg <= ALIGN_HUNT;
						err_run_reg  <= 3'h0;
					end else if (al_valid_reg && !bypass) begin
						err_run_reg <= dec[11] ? err_run_reg + 3'h1 : 3'h0;
					end
				end
				default: al_state_reg <= ALIGN_HUNT;
			endcase
		end else if (al_valid_reg && !bypass &&
				err_run_reg < `LOS_ERR_LIMIT) begin
			err_run_reg <= dec[11] ? err_run_reg + 3'h1 : 3'h0;
		end
	end

	// Aligned word register; alignment before decoding
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_reg     <= 10'h000;
			al_word_reg  <= 10'h000;
			al_valid_reg <= 1'b0;
		end else begin
			al_valid_reg <= rx_word_valid;
			if (rx_word_valid) begin
				prev_reg    <= rx_pol;
				al_word_reg <= window[19-off_use -: 10];
			end
		end
	end

	// Decode with running disparity
	assign dec = dec_word(al_word_reg, rx_rd_reg);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_rd_reg <= 1'b0;
		end else if (al_valid_reg && !bypass) begin
			rx_rd_reg <= dec[0];
		end
	end

	// Clock compensation on both FIFO ports
	logic [10:0]    rx_entry;
	logic           is_skip_in;
	logic           drop_skip;
	logic           fifo_in_ready;
	logic           fifo_out_valid;
	logic           fifo_out_ready;
	logic [10:0]    fifo_out_data;
	logic [FAW+1:0] fifo_level;
	logic           insert_skip;
	logic           take;
	logic           half;
	logic [10:0]    lo_reg;
	logic           have_lo_reg;

	// Bypass carries raw bits, eight or ten wide
	assign rx_entry = bypass ?
		{1'b0, ctrl_reg[`CTRL_RAW10] ? al_word_reg :
			{2'b00, al_word_reg[7:0]}} :
		{dec[9], 2'b00, dec[8:1]};
	assign is_skip_in = !bypass && ({dec[9], dec[8:1]} == skip_reg);
	// Deleting only at or above the mark keeps real data intact
	assign drop_skip = ctrl_reg[`CTRL_CTC_EN] && is_skip_in &&
		(fifo_level >= (FAW+2)'(`CTC_HIGH_MARK));
	assign insert_skip = ctrl_reg[`CTRL_CTC_EN] && !bypass &&
		({fifo_out_data[10], fifo_out_data[7:0]} == skip_reg) &&
		(fifo_level <= (FAW+2)'(`CTC_LOW_MARK));
	assign half = ctrl_reg[`CTRL_HALF];
	assign take = fifo_out_valid && (!rx_user_valid || rx_user_ready);
	// A repeated skip is read without popping it
	assign fifo_out_ready = take && !insert_skip;

	pcs_fifo #(
		.WIDTH (11),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.pclk      (pclk),
		.presetn   (presetn),
		.in_valid  (al_valid_reg && !drop_skip),
		.in_ready  (fifo_in_ready),
		.in_data   (rx_entry),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out_data),
		.level     (fifo_level)
	);

	// Fabric side: one word per beat, or a low/high pair
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_user_valid <= 1'b0;
			rx_user_data  <= 20'h00000;
			rx_user_k     <= 2'b00;
			lo_reg        <= 11'h000;
			have_lo_reg   <= 1'b0;
		end else begin
			if (rx_user_valid && rx_user_ready) begin
				rx_user_valid <= 1'b0;
			end
			if (take && half && !have_lo_reg) begin
				lo_reg      <= fifo_out_data;
				have_lo_reg <= 1'b1;
			end else if (take && half) begin
				rx_user_valid <= 1'b1;
				rx_user_data  <= {fifo_out_data[9:0], lo_reg[9:0]};
				rx_user_k     <= {fifo_out_data[10], lo_reg[10]};
				have_lo_reg   <= 1'b0;
			end else if (take) begin
				rx_user_valid <= 1'b1;
				rx_user_data  <= {10'h000, fifo_out_data[9:0]};
				rx_user_k     <= {1'b0, fifo_out_data[10]};
			end
			if (!half) begin
				have_lo_reg <= 1'b0;
			end
		end
	end

	// Transmit: encode, then polarity; high half follows low half
	logic [10:0] hi_reg;
	logic        hold_hi_reg;
	logic        tx_rd_reg;
	logic        tx_fire;
	logic [9:0]  tx_d;
	logic        tx_k;
	logic [10:0] tx_enc;
	logic [9:0]  tx_raw;

	assign tx_user_ready = !hold_hi_reg && (!tx_word_valid || tx_ser_ready);
	assign tx_fire = (!tx_word_valid || tx_ser_ready) &&
		(hold_hi_reg || tx_user_valid);
	assign tx_d = hold_hi_reg ? hi_reg[9:0] : tx_user_data[9:0];
	assign tx_k = hold_hi_reg ? hi_reg[10] : tx_user_k[0];
	assign tx_enc = enc_word(tx_d[7:0], tx_k, tx_rd_reg);
	assign tx_raw = bypass ? (ctrl_reg[`CTRL_RAW10] ? tx_d :
		{2'b00, tx_d[7:0]}) : tx_enc[9:0];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_word_valid <= 1'b0;
			tx_word       <= 10'h000;
			tx_rd_reg     <= 1'b0;
			hi_reg        <= 11'h000;
			hold_hi_reg   <= 1'b0;
		end else begin
			if (tx_word_valid && tx_ser_ready) begin
				tx_word_valid <= 1'b0;
			end
			if (tx_fire) begin
				tx_word_valid <= 1'b1;
				tx_word <= tx_raw ^ {10{ctrl_reg[`CTRL_TX_INV]}};
				if (!bypass) begin
					tx_rd_reg <= tx_enc[10];
				end
				hold_hi_reg <= !hold_hi_reg && half;
				if (!hold_hi_reg) begin
					hi_reg <= {tx_user_k[1], tx_user_data[19:10]};
				end
			end
		end
	end

	// Word strobes stand in for the per-direction word clocks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_word_strobe <= 1'b0;
			tx_word_strobe <= 1'b0;
		end else begin
			rx_word_strobe <= al_valid_reg;
			tx_word_strobe <= tx_word_valid && tx_ser_ready;
		end
	end

	// Sticky errors and compensation counters; set beats clear
	logic [2:0] st_set;
	logic [2:0] st_clr;

	assign st_set = {al_valid_reg && !fifo_in_ready && !drop_skip,
		al_valid_reg && !bypass && dec[11:10] == 2'b01,
		al_valid_reg && !bypass && dec[11]};
	assign st_clr = (wr_en && paddr == `REG_STATUS) ?
		pwdata[`ST_OVERFLOW:`ST_CODE_ERR] : 3'h0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sticky_reg  <= 3'h0;
			ins_cnt_reg <= 16'h0000;
			del_cnt_reg <= 16'h0000;
		end else begin
			sticky_reg <= (sticky_reg & ~st_clr) | st_set;
			if (take && insert_skip) begin
				ins_cnt_reg <= ins_cnt_reg + 16'h0001;
			end
			if (al_valid_reg && drop_skip) begin
				del_cnt_reg <= del_cnt_reg + 16'h0001;
			end
		end
	end

	// Read data prepared in the setup phase for zero-wait access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			pslverr <= 1'b0;
			case (paddr)
				`REG_CTRL:    prdata <= {25'h0, ctrl_reg};
				`REG_COMMA:   prdata <= {22'h0, comma_reg};
				`REG_SLIP:    prdata <= 32'h00000000;
				`REG_DUAL:    prdata <= {15'h0, granted, 7'h0, dual_reg};
				`REG_STATUS:  prdata <= {25'h0, mix_refused, sticky_reg,
					!fifo_in_ready, !fifo_out_valid,
					al_state_reg == ALIGN_LOCKED};
				`REG_CTC_CNT: prdata <= {del_cnt_reg, ins_cnt_reg};
				`REG_SKIP:    prdata <= {23'h0, skip_reg};
				default: begin
					prdata  <= 32'h00000000;
					pslverr <= 1'b1;
				end
			endcase
		end
	end
endmodule // serial_pcs_channel
`default_nettype wire

// ---- verif/serial_pcs_channel_asserts.sv ----
// Port-level assertions for the serial coding channel.
// Bound to the channel; sees only its top-level pins.
`timescale 1ns/1ps
`default_nettype none
`include "pcs_params.svh"
module pcs_checker (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        rx_word_valid,
	input wire logic        rx_word_strobe,
	input wire logic [19:0] rx_user_data,
	input wire logic        rx_user_valid,
	input wire logic        rx_user_ready,
	input wire logic        tx_user_valid,
	input wire logic        tx_user_ready,
	input wire logic [9:0]  tx_word,
	input wire logic        tx_word_valid,
	input wire logic        tx_ser_ready,
	input wire logic        tx_word_strobe,
	input wire logic        dual_shared
);
	logic grant_reg;
	logic acc;
	assign acc = psel && penable;
	// Expected split grant, tracked from writes to the dual register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			grant_reg <= 1'b0;
		else if (acc && pwrite && paddr == `REG_DUAL)
			grant_reg <= pwdata[8] && (pwdata[7:0] == 8'h01
				|| pwdata[7:0] == 8'h02 || pwdata[7:0] == 8'h0B);
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	apb_ready_a: assert property (pready)
		else $error("pready low");
	unmapped_err_a: assert property (
		acc && paddr > 8'h18 |-> pslverr)
		else $error("no error on unmapped address");
	mapped_ok_a: assert property (
		acc && paddr <= 8'h18 && paddr[1:0] == 2'h0 |-> !pslverr)
		else $error("error on mapped address");
	rx_strobe_a: assert property (
		rx_word_valid |-> ##[1:2] rx_word_strobe)
		else $error("no receive word strobe");
	rx_quiet_a: assert property (
		!rx_word_valid [*3] |-> !rx_word_strobe)
		else $error("receive strobe without word");
	rx_hold_a: assert property (
		rx_user_valid && !rx_user_ready
		|=> rx_user_valid && $stable(rx_user_data))
		else $error("receive beat dropped while stalled");
	tx_take_a: assert property (
		tx_user_valid && tx_user_ready |=> tx_word_valid)
		else $error("no code word after accepted beat");
	tx_hold_a: assert property (
		tx_word_valid && !tx_ser_ready |=> tx_word_valid && $stable(tx_word))
		else $error("code word changed while stalled");
	tx_strobe_a: assert property (
		tx_word_valid && tx_ser_ready |=> tx_word_strobe)
		else $error("no transmit word strobe");
	dual_unit_a: assert property (dual_shared == !grant_reg)
		else $error("dual sharing wrong");
endmodule // pcs_checker
`default_nettype wire

// ---- verif/pcs_serdes_model.sv ----
// Behavioural serializer and deserializer facing the channel.
// Assumes the bench calls send and idle right after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module serdes_model
	import pcs_types_pkg::*;
(
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       slow,
	output var code_word_t rx_word,
	output var logic       rx_word_valid,
	input wire code_word_t tx_word,
	input wire logic       tx_word_valid,
	output var logic       tx_ser_ready
);
	code_word_t got [$];
	logic       odd_reg;
	initial begin
		rx_word = 10'h000;
		rx_word_valid = 1'b0;
	end
	// Serializer takes a word at each ready edge; slow stalls every other
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			odd_reg <= 1'b0;
		end else begin
			odd_reg <= ~odd_reg;
			if (tx_word_valid && tx_ser_ready)
				got.push_back(tx_word);
		end
	end
	assign tx_ser_ready = !slow || odd_reg;
	// One ten-bit word per call
	task automatic send(input code_word_t w);
		@(posedge pclk);
		rx_word <= w;
		rx_word_valid <= 1'b1;
	endtask
	// No stale data between words: the data lines flip once per call
	task automatic idle();
		@(posedge pclk);
		rx_word <= ~rx_word;
		rx_word_valid <= 1'b0;
	endtask
endmodule // serdes_model
`default_nettype wire

// ---- verif/serial_pcs_channel_test.sv ----
// Self-checking bench for the serial coding channel.
// Assumes design, model and checker files are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "pcs_params.svh"
module serial_pcs_channel_test
	import pcs_types_pkg::*;
;
	logic        pclk = 1'b0, presetn = 1'b0, slow = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, v;
	logic        pready, pslverr, rx_word_valid, rx_user_valid, e;
	logic        bit_slip_req = 1'b0, rx_user_ready = 1'b0;
	logic        tx_user_valid = 1'b0;
	logic [1:0]  tx_user_k = 2'h0, rx_user_k, k;
	logic [19:0] tx_user_data = 20'h0, rx_user_data, d;
	logic        tx_user_ready, tx_word_valid, tx_ser_ready;
	logic        rx_word_strobe, tx_word_strobe, dual_shared;
	code_word_t  rx_word, tx_word;
	int          num_errors = 0;
	int          check_count = 0;
	// 100 MHz
	always #5 pclk = ~pclk;
	serial_pcs_channel #(.FIFO_DEPTH(32)) DUT (.pclk, .presetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.rx_word, .rx_word_valid, .bit_slip_req, .rx_user_data,
		.rx_user_k, .rx_user_valid, .rx_user_ready, .rx_word_strobe,
		.tx_user_data, .tx_user_k, .tx_user_valid, .tx_user_ready,
		.tx_word, .tx_word_valid, .tx_ser_ready, .tx_word_strobe,
		.dual_shared);
	serdes_model sd (.pclk, .presetn, .slow, .rx_word, .rx_word_valid,
		.tx_word, .tx_word_valid, .tx_ser_ready);
	task automatic check(input string what, input logic [31:0] x, g);
		check_count++;
		if (g !== x) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, x, g);
		end
	endtask
	task automatic stuck(input string what);
		num_errors++;
		$display("BAD %s expected done seen timeout", what);
		wrap_up();
	endtask
	// One APB transfer; read data and error kept in v and e
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] wd);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 50);
		if (pready !== 1'b1) stuck("pready");
		v = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdc(input string what, input logic [7:0] a,
		input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		check(what, x, v);
	endtask
	// Takes one receive beat; data settled before the taking edge
	task automatic get_rx();
		int i;
		@(posedge pclk);
		rx_user_ready <= 1'b1;
		i = 0;
		@(negedge pclk);
		while (rx_user_valid !== 1'b1 && i < 200) begin
			@(negedge pclk);
			i++;
		end
		if (i == 200) stuck("rx_user_valid");
		d = rx_user_data;
		k = rx_user_k;
		@(posedge pclk);
		rx_user_ready <= 1'b0;
	endtask
	// Empties the receive path: eight quiet cycles in a row
	task automatic drain();
		int i;
		int n;
		@(posedge pclk);
		rx_user_ready <= 1'b1;
		i = 0;
		n = 0;
		while (n < 8 && i < 300) begin
			@(negedge pclk);
			n = (rx_user_valid === 1'b1) ? 0 : n + 1;
			i++;
		end
		if (i == 300) stuck("drain");
		@(posedge pclk);
		rx_user_ready <= 1'b0;
	endtask
	task automatic send_tx(input logic [19:0] x, input logic [1:0] kk);
		int i;
		@(posedge pclk);
		tx_user_valid <= 1'b1;
		tx_user_data <= x;
		tx_user_k <= kk;
		i = 0;
		@(negedge pclk);
		while (tx_user_ready !== 1'b1 && i < 50) begin
			@(negedge pclk);
			i++;
		end
		if (i == 50) stuck("tx_user_ready");
		@(posedge pclk);
		tx_user_valid <= 1'b0;
	endtask
	task automatic do_reset();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
	endtask
	task automatic t_regs();
		rdc("ctrl", `REG_CTRL, `CTRL_RESET);
		rdc("comma", `REG_COMMA, `COMMA_RESET);
		rdc("dual", `REG_DUAL, `DUAL_RESET);
		rdc("skip", `REG_SKIP, `SKIP_RESET);
		rdc("ctc count", `REG_CTC_CNT, 32'h0);
		rdc("status", `REG_STATUS, 32'h2);
		rdc("unmapped", 8'h1C, 32'h0);
		check("unmapped err", 1'b1, e);
		check("shared", 1'b1, dual_shared);
	endtask
	task automatic t_dual();
		logic [7:0] r [5] = '{8'h01, 8'h02, 8'h0B, 8'h03, 8'h00};
		logic       g;
		foreach (r[j]) begin
			g = r[j] == 8'h01 || r[j] == 8'h02 || r[j] == 8'h0B;
			apb(1'b1, `REG_DUAL, {23'h0, 1'b1, r[j]});
			rdc("dual", `REG_DUAL, {15'h0, g, 7'h0, 1'b1, r[j]});
			check("shared", !g, dual_shared);
			apb(1'b0, `REG_STATUS, 32'h0);
			check("mix refused", !g, v[6]);
		end
		apb(1'b1, `REG_DUAL, `DUAL_RESET);
	endtask
	// K28.5 from negative then positive disparity, then inverted, then raw
	task automatic t_tx();
		int i;
		@(posedge pclk);
		slow <= 1'b1;
		send_tx(20'h000BC, 2'h1);
		send_tx(20'h000BC, 2'h1);
		apb(1'b1, `REG_CTRL, 32'h62);
		send_tx(20'h000BC, 2'h1);
		apb(1'b1, `REG_CTRL, 32'h1C);
		send_tx({10'h2AB, 10'h155}, 2'h0);
		for (i = 0; i < 100 && sd.got.size() < 5; i++) @(negedge pclk);
		if (i == 100) stuck("tx words");
		check("tx comma", 10'h0FA, sd.got[0]);
		check("tx comma rd+", 10'h305, sd.got[1]);
		check("tx inverted", 10'h305, sd.got[2]);
		check("tx half low", 10'h155, sd.got[3]);
		check("tx half high", 10'h2AB, sd.got[4]);
	endtask
	task automatic commas();
		repeat (2) begin
			sd.send(10'h0FA);
			sd.send(10'h305);
		end
		sd.idle();
	endtask
	task automatic t_rx_code();
		apb(1'b1, `REG_CTRL, `CTRL_RESET);
		commas();
		commas();
		apb(1'b0, `REG_STATUS, 32'h0);
		check("aligned", 1'b1, v[0]);
		drain();
		commas();
		repeat (4) begin
			get_rx();
			check("rx decoded", 20'h000BC, d);
			check("rx k", 2'h1, k);
		end
		@(posedge pclk);
		bit_slip_req <= 1'b1;
		@(posedge pclk);
		bit_slip_req <= 1'b0;
		commas();
		get_rx();
		check("slip moved", 1'b1, {k[0], d[7:0]} != 9'h1BC);
		apb(1'b0, `REG_STATUS, 32'h0);
		check("code err", 1'b1, v[3]);
		drain();
	endtask
	// Raw words after a mid-run reset: ten bits, inverted, eight bits
	task automatic t_bypass();
		logic [31:0] c [3] = '{32'h0C, 32'h0D, 32'h04};
		code_word_t  w [3] = '{10'h155, 10'h155, 10'h3A5};
		logic [19:0] x [3] = '{20'h00155, 20'h002AA, 20'h000A5};
		logic [19:0] m [3] = '{20'hFFFFF, 20'hFFFFF, 20'h000FF};
		do_reset();
		foreach (c[j]) begin
			apb(1'b1, `REG_CTRL, c[j]);
			sd.send(w[j]);
			sd.idle();
			get_rx();
			check("bypass", x[j], d & m[j]);
		end
		apb(1'b1, `REG_CTRL, 32'h1C);
		sd.send(10'h155);
		sd.send(10'h2AB);
		sd.idle();
		get_rx();
		check("half rate", {10'h2AB, 10'h155}, d);
	endtask
	task automatic t_fifo();
		apb(1'b1, `REG_CTRL, 32'h0C);
		for (int j = 0; j < 40; j++) sd.send(10'h040 + 10'(j));
		sd.idle();
		apb(1'b0, `REG_STATUS, 32'h0);
		check("fifo full", 1'b1, v[2]);
		check("overflow", 1'b1, v[5]);
		get_rx();
		check("oldest kept", 20'h00040, d);
		drain();
		apb(1'b1, `REG_STATUS, 32'h20);
		apb(1'b0, `REG_STATUS, 32'h0);
		check("overflow cleared", 1'b0, v[5]);
		check("fifo empty", 1'b1, v[1]);
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_dual();
		t_tx();
		t_rx_code();
		t_bypass();
		t_fifo();
		wrap_up();
	end
endmodule // serial_pcs_channel_test
bind serial_pcs_channel pcs_checker u_chk (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
	.rx_word_valid, .rx_word_strobe, .rx_user_data, .rx_user_valid,
	.rx_user_ready, .tx_user_valid, .tx_user_ready, .tx_word,
	.tx_word_valid, .tx_ser_ready, .tx_word_strobe, .dual_shared);
`default_nettype wire
